// *** hw/dag_pkg.sv ***
// Shared constants and carrier types for the DSP data address generator
// Functional notes
// [RULE_01] Dual X side uses R4/R5 with step R8; Y side R6/R7 with step R9.
// [RULE_02] Single moves use pointer R4, R5, R2 or R3 and step R8.
// [RULE_03] A dual move issues one X and one Y access, each own pointer.
// [RULE_04] Dual non-update mode addresses by pointers and leaves them unchanged.
// [RULE_05] Dual increment mode adds two to each pointer afterwards.
// [RULE_06] Dual index mode adds X step to X pointer, Y step to Y.
// [RULE_07] Software gets decreasing dual addresses by loading minus two as step.
// [RULE_08] Bit zero of the pointer is ignored for X and Y addresses.
// [RULE_09] Software keeps bit zero of dual pointers and steps at zero.
// [RULE_10] Upper sixteen pointer bits are ignored on the X and Y buses.
// [RULE_11] Y pointer update writes only the low half, upper half kept.
// [RULE_12] X pointer update is a full 32-bit add storing every bit.
// [RULE_13] Single non-update mode accesses the pointer value, pointer unchanged.
// [RULE_14] Single increment adds two for word or four for longword afterwards.
// [RULE_15] Single index mode adds the single step register afterwards.
// [RULE_16] Single decrement subtracts two or four first and uses that address.
// [RULE_17] Single moves use all 32 pointer bits as the address.
// [RULE_18] Single moves go over the shared bus and may wait for it.
// [RULE_19] With wrap on, pre-update pointer equal to wrap end loads wrap start.
// [RULE_20] With both wrap enables set, only the Y side wraps.
// [RULE_21] All address generation and update happen in the memory-access stage.
// [RULE_22] Step registers are signed two's complement values.
package dag_pkg;

  // Widths
  localparam int PTR_W = 32;
  localparam int XY_W  = 16;

  // Pointer file holds R2..R9; slot = register number minus REG_LO
  localparam logic [3:0] REG_LO  = 4'h2;
  localparam logic [3:0] REG_HI  = 4'h9;
  localparam logic [2:0] SLOT_R2 = 3'h0;
  localparam logic [2:0] SLOT_R3 = 3'h1;
  localparam logic [2:0] SLOT_R4 = 3'h2;
  localparam logic [2:0] SLOT_R5 = 3'h3;
  localparam logic [2:0] SLOT_R6 = 3'h4;
  localparam logic [2:0] SLOT_R7 = 3'h5;
  localparam logic [2:0] SLOT_R8 = 3'h6;
  localparam logic [2:0] SLOT_R9 = 3'h7;

  // Single-move pointer select codes
  localparam logic [1:0] SSEL_R4 = 2'h0;
  localparam logic [1:0] SSEL_R5 = 2'h1;
  localparam logic [1:0] SSEL_R2 = 2'h2;

  // Dual-move mode codes, per side
  localparam logic [1:0] XY_MODE_NONE  = 2'h0;
  localparam logic [1:0] XY_MODE_KEEP  = 2'h1;
  localparam logic [1:0] XY_MODE_INC   = 2'h2;
  localparam logic [1:0] XY_MODE_INDEX = 2'h3;

  // Single-move mode codes
  localparam logic [1:0] S_MODE_DEC   = 2'h0;
  localparam logic [1:0] S_MODE_KEEP  = 2'h1;
  localparam logic [1:0] S_MODE_INC   = 2'h2;
  localparam logic [1:0] S_MODE_INDEX = 2'h3;

  // Fixed increments and reset values
  localparam logic [31:0] STEP_WORD = 32'h0000_0002;
  localparam logic [31:0] STEP_LONG = 32'h0000_0004;
  localparam logic [31:0] PTR_RESET = 32'h0000_0000;

  // Single-move sequencer
  typedef enum logic [1:0] {
    DAG_S_IDLE = 2'b01,
    DAG_S_WAIT = 2'b10
  } dag_sstate_t;

  typedef struct packed {
    logic       sel;
    logic [1:0] mode;
  } dag_xy_op_t;

  typedef struct packed {
    logic       valid;
    dag_xy_op_t x;
    dag_xy_op_t y;
  } dag_dual_req_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] sel;
    logic [1:0] mode;
    logic       is_long;
  } dag_single_req_t;

  typedef struct packed {
    logic        en;
    logic [3:0]  idx;
    logic [31:0] data;
  } dag_reg_wr_t;

  typedef struct packed {
    logic        x_wrap_enable;
    logic        y_wrap_enable;
    logic [15:0] wrap_start_addr;
    logic [15:0] wrap_end_addr;
  } dag_wrap_cfg_t;

  typedef struct packed {
    logic [7:0][31:0] ptr;
    logic             x_req;
    logic [15:0]      x_addr;
    logic             y_req;
    logic [15:0]      y_addr;
    dag_sstate_t      sstate;
    logic             l_req;
    logic [31:0]      l_addr;
    logic             l_long;
    logic [2:0]       pend_slot;
    logic [31:0]      pend_ptr;
    logic             pend_upd;
    logic             single_busy;
    logic             single_done;
    logic [31:0]      rd_data;
  } dag_state_t;

endpackage

// *** hw/dag_single_calc.sv ***
// Address and pointer update for a single move
`timescale 1ns/1ps
module dag_single_calc (
  // Operands
  input  wire logic [31:0] ptr,
  input  wire logic [31:0] step,
  input  wire logic [1:0]  mode,
  input  wire logic        is_long,
  // Results
  output logic [31:0]      addr,
  output logic [31:0]      next_ptr,
  output logic             upd
);

  logic [31:0] size;

  // Full 32-bit address, no bits dropped
  always_comb
  begin
    size     = is_long ? dag_pkg::STEP_LONG : dag_pkg::STEP_WORD;
    addr     = ptr;                                     // RULE_17
    next_ptr = ptr;
    upd      = 1'b0;
    unique case (mode)
      dag_pkg::S_MODE_DEC:
      begin
        addr     = ptr - size;                          // RULE_16
        next_ptr = ptr - size;
        upd      = 1'b1;
      end
      dag_pkg::S_MODE_KEEP:
      begin
        upd = 1'b0;                                     // RULE_13
      end
      dag_pkg::S_MODE_INC:
      begin
        next_ptr = ptr + size;                          // RULE_14
        upd      = 1'b1;
      end
      dag_pkg::S_MODE_INDEX:
      begin
        next_ptr = ptr + step;                          // RULE_15
        upd      = 1'b1;
      end
    endcase
  end

endmodule

// *** hw/dag_top.sv ***
// DSP data address generator: pointer file, dual X/Y moves, single moves
`timescale 1ns/1ps
module dag_top (
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      reset,
  // Pointer register writes and readback from the pipeline
  input  wire dag_pkg::dag_reg_wr_t      reg_wr,
  input  wire logic [3:0]                reg_rd_idx,
  output logic [31:0]                    reg_rd_data,
  // Wrap configuration
  input  wire dag_pkg::dag_wrap_cfg_t    wrap_cfg,
  // Memory-access stage move requests
  input  wire dag_pkg::dag_dual_req_t    dual_req,
  input  wire dag_pkg::dag_single_req_t  single_req,
  // X and Y data memory buses
  output logic                           xbus_req,
  output logic [15:0]                    xbus_addr,
  output logic                           ybus_req,
  output logic [15:0]                    ybus_addr,
  // Shared bus
  output logic                           lbus_req,
  output logic [31:0]                    lbus_addr,
  output logic                           lbus_long,
  input  wire logic                      lbus_gnt,
  // Single move status
  output logic                           single_busy,
  output logic                           single_done
);

  dag_pkg::dag_state_t st_q;
  dag_pkg::dag_state_t st_d;

  logic [2:0]  x_slot;
  logic [2:0]  y_slot;
  logic [2:0]  s_slot;
  logic [31:0] x_ptr_cur;
  logic [31:0] y_ptr_cur;
  logic [31:0] s_ptr_cur;
  logic        x_wrap_on;
  logic        y_wrap_on;
  logic [15:0] x_addr_c;
  logic [31:0] x_next_c;
  logic        x_upd_c;
  logic [15:0] y_addr_c;
  logic [31:0] y_next_c;
  logic        y_upd_c;
  logic [31:0] s_addr_c;
  logic [31:0] s_next_c;
  logic        s_upd_c;
  logic        wr_hit;
  logic [2:0]  wr_slot;
  logic        rd_hit;
  logic [2:0]  rd_slot;
  logic        s_wb;
  logic        x_clean;
  logic        y_clean;
  logic [15:0] x_even;
  logic [15:0] y_even;

  //////////////////////////////////////////////////////////////////////////////
  // Pointer selection

  // Fixed register roles per move type
  always_comb
  begin
    x_slot = dual_req.x.sel ? dag_pkg::SLOT_R5 : dag_pkg::SLOT_R4;        // RULE_01
    y_slot = dual_req.y.sel ? dag_pkg::SLOT_R7 : dag_pkg::SLOT_R6;        // RULE_01
    unique case (single_req.sel)                                          // RULE_02
      dag_pkg::SSEL_R4: s_slot = dag_pkg::SLOT_R4;
      dag_pkg::SSEL_R5: s_slot = dag_pkg::SLOT_R5;
      dag_pkg::SSEL_R2: s_slot = dag_pkg::SLOT_R2;
      default:          s_slot = dag_pkg::SLOT_R3;
    endcase
  end

  // Current pointer values and even low halves
  assign x_ptr_cur = st_q.ptr[x_slot];
  assign y_ptr_cur = st_q.ptr[y_slot];
  assign s_ptr_cur = st_q.ptr[s_slot];
  assign x_even    = {x_ptr_cur[15:1], 1'b0};
  assign y_even    = {y_ptr_cur[15:1], 1'b0};

  // Only one side may wrap; Y takes precedence
  assign x_wrap_on = wrap_cfg.x_wrap_enable && !wrap_cfg.y_wrap_enable;   // RULE_20
  assign y_wrap_on = wrap_cfg.y_wrap_enable;                              // RULE_20

  // Pipeline write and readback decode
  assign wr_hit  = reg_wr.en && (reg_wr.idx >= dag_pkg::REG_LO) && (reg_wr.idx <= dag_pkg::REG_HI);
  assign wr_slot = 3'(reg_wr.idx - dag_pkg::REG_LO);
  assign rd_hit  = (reg_rd_idx >= dag_pkg::REG_LO) && (reg_rd_idx <= dag_pkg::REG_HI);
  assign rd_slot = 3'(reg_rd_idx - dag_pkg::REG_LO);

  // Single write-back happens on the grant cycle
  assign s_wb = (st_q.sstate == dag_pkg::DAG_S_WAIT) && lbus_gnt && st_q.pend_upd;

  // Helper terms: no competing writer to the side's pointer this cycle
  assign x_clean = !(wr_hit && (wr_slot == x_slot)) && !(s_wb && (st_q.pend_slot == x_slot));
  assign y_clean = !(wr_hit && (wr_slot == y_slot)) && !(s_wb && (st_q.pend_slot == y_slot));

  //////////////////////////////////////////////////////////////////////////////
  // Arithmetic units

  // X side updates all 32 bits
  dag_xy_upd #(
    .KEEP_UPPER (1'b0)
  ) u_x_upd (
    .ptr      (x_ptr_cur),
    .step     (st_q.ptr[dag_pkg::SLOT_R8]),
    .mode     (dual_req.x.mode),
    .wrap_on  (x_wrap_on),
    .wrap_cfg (wrap_cfg),
    .addr     (x_addr_c),
    .next_ptr (x_next_c),
    .upd      (x_upd_c)
  );

  // Y side keeps its upper half
  dag_xy_upd #(
    .KEEP_UPPER (1'b1)
  ) u_y_upd (
    .ptr      (y_ptr_cur),
    .step     (st_q.ptr[dag_pkg::SLOT_R9]),
    .mode     (dual_req.y.mode),
    .wrap_on  (y_wrap_on),
    .wrap_cfg (wrap_cfg),
    .addr     (y_addr_c),
    .next_ptr (y_next_c),
    .upd      (y_upd_c)
  );

  // Single move uses R8 as its step
  dag_single_calc u_s_calc (
    .ptr      (s_ptr_cur),
    .step     (st_q.ptr[dag_pkg::SLOT_R8]),
    .mode     (single_req.mode),
    .is_long  (single_req.is_long),
    .addr     (s_addr_c),
    .next_ptr (s_next_c),
    .upd      (s_upd_c)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  // Writers in rising priority: pipeline write, single write-back, dual update
  always_comb
  begin
    st_d             = st_q;
    st_d.x_req       = 1'b0;
    st_d.y_req       = 1'b0;
    st_d.single_done = 1'b0;
    st_d.rd_data     = rd_hit ? st_q.ptr[rd_slot] : dag_pkg::PTR_RESET;

    if (wr_hit)
      st_d.ptr[wr_slot] = reg_wr.data;

    // Single moves: request held on the shared bus until granted
    unique case (st_q.sstate)
      dag_pkg::DAG_S_IDLE:
      begin
        if (single_req.valid)
        begin
          st_d.l_req       = 1'b1;                                         // RULE_18
          st_d.l_addr      = s_addr_c;                                     // RULE_17
          st_d.l_long      = single_req.is_long;
          st_d.pend_slot   = s_slot;
          st_d.pend_ptr    = s_next_c;
          st_d.pend_upd    = s_upd_c;
          st_d.single_busy = 1'b1;
          st_d.sstate      = dag_pkg::DAG_S_WAIT;
        end
      end
      dag_pkg::DAG_S_WAIT:
      begin
        // Instruction fetch may hold the bus; keep waiting
        if (lbus_gnt)
        begin
          st_d.l_req       = 1'b0;
          st_d.single_busy = 1'b0;
          st_d.single_done = 1'b1;
          st_d.sstate      = dag_pkg::DAG_S_IDLE;
          if (st_q.pend_upd)
            st_d.ptr[st_q.pend_slot] = st_q.pend_ptr;                      // RULE_14
        end
      end
      default:
      begin
        st_d.sstate = dag_pkg::DAG_S_IDLE;
      end
    endcase

    // Dual moves: both sides in the same memory-access cycle
    if (dual_req.valid)                                                    // RULE_21
    begin
      if (dual_req.x.mode != dag_pkg::XY_MODE_NONE)
      begin
        st_d.x_req  = 1'b1;                                                // RULE_03
        st_d.x_addr = x_addr_c;                                            // RULE_10
        if (x_upd_c)
          st_d.ptr[x_slot] = x_next_c;                                     // RULE_06
      end
      if (dual_req.y.mode != dag_pkg::XY_MODE_NONE)
      begin
        st_d.y_req  = 1'b1;                                                // RULE_03
        st_d.y_addr = y_addr_c;                                            // RULE_10
        if (y_upd_c)
          st_d.ptr[y_slot] = y_next_c;                                     // RULE_06
      end
    end

    // Synchronous reset overrides everything
    if (reset)
    begin
      st_d        = '0;
      st_d.sstate = dag_pkg::DAG_S_IDLE;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge mclk)
  begin
    st_q <= st_d;
  end

  // Every output comes straight from the state register
  assign reg_rd_data = st_q.rd_data;
  assign xbus_req    = st_q.x_req;
  assign xbus_addr   = st_q.x_addr;
  assign ybus_req    = st_q.y_req;
  assign ybus_addr   = st_q.y_addr;
  assign lbus_req    = st_q.l_req;
  assign lbus_addr   = st_q.l_addr;
  assign lbus_long   = st_q.l_long;
  assign single_busy = st_q.single_busy;
  assign single_done = st_q.single_done;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking dag_cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  // X address is the even low half of the chosen pointer
  a_x_addr_form: assert property (                                       // RULE_08
    dual_req.valid && dual_req.x.mode != dag_pkg::XY_MODE_NONE
    |=> xbus_req && xbus_addr == $past(x_even))
    else $error("X address not formed from pointer");

  // Y access issued together with X access
  a_xy_same_cycle: assert property (                                     // RULE_03
    dual_req.valid && dual_req.x.mode != dag_pkg::XY_MODE_NONE
    && dual_req.y.mode != dag_pkg::XY_MODE_NONE
    |=> xbus_req && ybus_req && ybus_addr == $past(y_even))
    else $error("Dual move did not issue both accesses");

  // Non-update leaves the X pointer alone
  a_x_keep_ptr: assert property (                                        // RULE_04
    dual_req.valid && dual_req.x.mode == dag_pkg::XY_MODE_KEEP && x_clean
    |=> st_q.ptr[$past(x_slot)] == $past(x_ptr_cur))
    else $error("X pointer changed in non-update mode");

  // Increment adds two when no wrap is armed
  a_x_inc_two: assert property (                                         // RULE_05
    dual_req.valid && dual_req.x.mode == dag_pkg::XY_MODE_INC && x_clean && !x_wrap_on
    |=> st_q.ptr[$past(x_slot)] == $past(x_ptr_cur) + dag_pkg::STEP_WORD)
    else $error("X pointer not incremented by two");

  // Y index update keeps upper half and adds step to the lower
  a_y_index_low: assert property (                                       // RULE_11
    dual_req.valid && dual_req.y.mode == dag_pkg::XY_MODE_INDEX && y_clean && !y_wrap_on
    |=> st_q.ptr[$past(y_slot)][31:16] == $past(y_ptr_cur[31:16])
    && st_q.ptr[$past(y_slot)][15:0] == 16'($past(y_ptr_cur) + $past(st_q.ptr[dag_pkg::SLOT_R9])))
    else $error("Y pointer index update wrong");

  // With both enables, an X pointer at the end address still just steps
  a_wrap_y_only: assert property (                                       // RULE_20
    dual_req.valid && dual_req.x.mode == dag_pkg::XY_MODE_INC && x_clean
    && wrap_cfg.x_wrap_enable && wrap_cfg.y_wrap_enable
    |=> st_q.ptr[$past(x_slot)] == $past(x_ptr_cur) + dag_pkg::STEP_WORD)
    else $error("X side wrapped while Y wrap enabled");

  // Decrement addresses with the lowered pointer
  a_s_dec_addr: assert property (                                        // RULE_16
    st_q.sstate == dag_pkg::DAG_S_IDLE && single_req.valid
    && single_req.mode == dag_pkg::S_MODE_DEC && single_req.is_long
    |=> lbus_req && lbus_addr == $past(s_ptr_cur) - dag_pkg::STEP_LONG)
    else $error("Single decrement address wrong");

  // Request held steady while the shared bus is busy
  a_l_hold: assert property (                                            // RULE_18
    lbus_req && !lbus_gnt |=> lbus_req && $stable(lbus_addr) && single_busy)
    else $error("Shared bus request dropped before grant");

  // Grant ends the request and reports completion next cycle
  a_l_done: assert property (                                            // RULE_18
    lbus_req && lbus_gnt |=> !lbus_req && single_done ##1 !single_done)
    else $error("Single move completion wrong");

  // X index step spans all 32 bits
  a_x_index_add: assert property ( // RULE_06
    dual_req.valid
    && !x_wrap_on
    && dual_req.x.mode ==
    dag_pkg::XY_MODE_INDEX
    |=> st_q.ptr[$past(x_slot)] ==
    $past(x_ptr_cur) +
    $past(st_q.ptr[dag_pkg::SLOT_R8]))
    else $error("X index step wrong");

  // Y at its end address reloads the start
  a_y_wrap_load: assert property ( // RULE_19
    dual_req.valid
    && y_wrap_on
    && dual_req.y.mode == dag_pkg::XY_MODE_INC
    && y_ptr_cur[15:1] == wrap_cfg.wrap_end_addr[15:1]
    |=> st_q.ptr[$past(y_slot)][15:0] ==
    $past(wrap_cfg.wrap_start_addr))
    else $error("Y wrap not applied");

  // Other single modes address the pointer
  a_s_ptr_addr: assert property ( // RULE_17
    single_req.valid
    && !single_busy
    && single_req.mode != dag_pkg::S_MODE_DEC
    |=> lbus_addr ==
    $past(s_ptr_cur))
    else $error("Single address wrong");

  // Word increment books pointer plus two
  a_s_inc_word: assert property ( // RULE_14
    single_req.valid
    && !single_busy
    && !single_req.is_long
    && single_req.mode == dag_pkg::S_MODE_INC
    |=> st_q.pend_ptr ==
    $past(s_ptr_cur) +
    dag_pkg::STEP_WORD)
    else $error("Single increment wrong");

endmodule

// *** hw/dag_xy_upd.sv ***
// Address and post-update for one side of a dual move
`timescale 1ns/1ps
module dag_xy_upd #(
  parameter bit KEEP_UPPER = 1'b0
) (
  // Operands
  input  wire logic [31:0]          ptr,
  input  wire logic [31:0]          step,
  input  wire logic [1:0]           mode,
  // Wrap control
  input  wire logic                 wrap_on,
  input  wire dag_pkg::dag_wrap_cfg_t wrap_cfg,
  // Results
  output logic [15:0]               addr,
  output logic [31:0]               next_ptr,
  output logic                      upd
);

  logic [31:0] step_v;
  logic [31:0] sum;
  logic        hit;
  logic [15:0] low;

  // Signed add; a step of minus two walks downward
  always_comb
  begin
    addr   = {ptr[15:1], 1'b0};                                             // RULE_08
    step_v = (mode == dag_pkg::XY_MODE_INC) ? dag_pkg::STEP_WORD : step;    // RULE_05
    sum    = ptr + step_v;                                                  // RULE_22
    upd    = (mode == dag_pkg::XY_MODE_INC) || (mode == dag_pkg::XY_MODE_INDEX);
    // Index steps may overshoot the end address; that is left unwrapped
    hit    = wrap_on && upd && (ptr[15:1] == wrap_cfg.wrap_end_addr[15:1]); // RULE_19
    low    = hit ? wrap_cfg.wrap_start_addr : sum[15:0];
    if (KEEP_UPPER)
      next_ptr = {ptr[31:16], low};                                         // RULE_11
    else if (hit)
      next_ptr = {ptr[31:16], wrap_cfg.wrap_start_addr};
    else
      next_ptr = sum;                                                       // RULE_12
  end

endmodule

// *** test/dag_lbus_model.sv ***
// Shared-bus partner model: grants a pending request after a set wait
`timescale 1ns/1ps
module dag_lbus_model (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       reset,
  // Bus handshake
  input  wire logic       lbus_req,
  input  wire logic [1:0] delay,
  output logic            lbus_gnt
);
  logic [1:0] wait_q;

  ////////////////////////////////////////////////////////////////
  // Wait counter; a long wait stands in for fetches holding the bus
  always_ff @(posedge mclk)
  begin
    if (reset || !lbus_req || lbus_gnt)
      wait_q <= 2'h0;
    else
      wait_q <= wait_q + 2'h1;
  end

  // Grant only while requested, so an idle bus never shows a stale grant
  assign lbus_gnt = lbus_req && (wait_q >= delay);
endmodule

// *** test/tb.sv ***
// Self-checking bench for the data address generator
`timescale 1ns/1ps
module tb;
  logic                     mclk, reset, xbus_req, ybus_req, lbus_req, lbus_long, lbus_gnt, single_busy, single_done;
  dag_pkg::dag_reg_wr_t     reg_wr;
  logic [3:0]               reg_rd_idx;
  logic [31:0]              reg_rd_data, lbus_addr;
  dag_pkg::dag_wrap_cfg_t   wrap_cfg;
  dag_pkg::dag_dual_req_t   dual_req;
  dag_pkg::dag_single_req_t single_req;
  logic [15:0]              xbus_addr, ybus_addr;
  logic [1:0]               delay;
  logic [7:0]               v;
  logic [31:0]              r [2:9];
  logic [32:0]              qx[$], qy[$], ql[$];
  int                       n_mismatch, num_checks, cyc;

  initial mclk = 1'b0;
  always #4 mclk = ~mclk;

  dag_top dut_u (.mclk(mclk), .reset(reset), .reg_wr(reg_wr), .reg_rd_idx(reg_rd_idx), .reg_rd_data(reg_rd_data),
    .wrap_cfg(wrap_cfg), .dual_req(dual_req), .single_req(single_req), .xbus_req(xbus_req), .xbus_addr(xbus_addr),
    .ybus_req(ybus_req), .ybus_addr(ybus_addr), .lbus_req(lbus_req), .lbus_addr(lbus_addr), .lbus_long(lbus_long),
    .lbus_gnt(lbus_gnt), .single_busy(single_busy), .single_done(single_done));
  dag_lbus_model pm_u (.mclk(mclk), .reset(reset), .lbus_req(lbus_req), .delay(delay), .lbus_gnt(lbus_gnt));

  ////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Reference post-update for one dual side; wrap only in the stepping modes
  function automatic logic [31:0] xy_next(input logic [31:0] p, input logic [31:0] s, input logic [1:0] m,
                                          input logic wrap, input logic keep);
    logic [31:0] n;
    n = p + ((m == dag_pkg::XY_MODE_INC) ? dag_pkg::STEP_WORD : s);
    if (keep)
      n[31:16] = p[31:16];
    if (wrap && p[15:1] == wrap_cfg.wrap_end_addr[15:1])
      n = {p[31:16], wrap_cfg.wrap_start_addr};
    return (m < dag_pkg::XY_MODE_INC) ? p : n;
  endfunction

  ////////////////////////////////////////////////////////////////
  // Drivers; all called at a falling edge
  task automatic wr(input logic [3:0] idx, input logic [31:0] d);
    reg_wr = {1'b1, idx, d};
    if (idx >= 4'h2 && idx <= 4'h9)
      r[idx] = d;
    @(negedge mclk);
    reg_wr.en = 1'b0;
    @(negedge mclk);
  endtask

  task automatic rd(input logic [3:0] idx, input logic [31:0] exp);
    reg_rd_idx = idx;
    @(negedge mclk);
    check({1'b0, reg_rd_data}, {1'b0, exp});
  endtask

  task automatic chk_all;
    for (int i = 2; i <= 9; i++)
      rd(4'(i), r[i]);
    rd(4'ha, 32'h0000_0000);
  endtask

  // Held valid on return so moves can run back to back; idle ends a burst
  task automatic dual(input logic xs, input logic [1:0] xm, input logic ys, input logic [1:0] ym);
    logic [31:0] px, py;
    px = r[4 + xs];
    py = r[6 + ys];
    dual_req = {1'b1, xs, xm, ys, ym};
    if (xm != dag_pkg::XY_MODE_NONE)
      qx.push_back({17'h0, px[15:1], 1'b0});
    if (ym != dag_pkg::XY_MODE_NONE)
      qy.push_back({17'h0, py[15:1], 1'b0});
    r[4 + xs] = xy_next(px, r[8], xm, wrap_cfg.x_wrap_enable && !wrap_cfg.y_wrap_enable, 1'b0);
    r[6 + ys] = xy_next(py, r[9], ym, wrap_cfg.y_wrap_enable, 1'b1);
    @(negedge mclk);
  endtask

  task automatic idle;
    dual_req.valid = 1'b0;
    @(negedge mclk);
  endtask

  // Poke re-presents a request while busy; it must be ignored
  task automatic single(input logic [1:0] sel, input logic [1:0] m, input logic lng, input logic poke);
    int i, k;
    logic [31:0] p, inc, a;
    i = (sel < 2'h2) ? 4 + sel : sel;
    p = r[i];
    inc = lng ? dag_pkg::STEP_LONG : dag_pkg::STEP_WORD;
    a = (m == dag_pkg::S_MODE_DEC) ? p - inc : p;
    single_req = {1'b1, sel, m, lng};
    ql.push_back({lng, a});
    if (m == dag_pkg::S_MODE_DEC)
      r[i] = a;
    else if (m == dag_pkg::S_MODE_INC)
      r[i] = p + inc;
    else if (m == dag_pkg::S_MODE_INDEX)
      r[i] = p + r[8];
    @(negedge mclk);
    check({32'h0, single_busy}, 33'h1);
    if (poke)
    begin
      single_req.sel = ~sel;
      @(negedge mclk);
    end
    single_req.valid = 1'b0;
    k = 0;
    while (single_done !== 1'b1 && k < 20)
    begin
      @(negedge mclk);
      k++;
    end
    check({31'h0, single_busy, single_done}, 33'h1);
  endtask

  ////////////////////////////////////////////////////////////////
  // Monitor: one pop per access seen; X/Y one cycle after the request, shared bus on the grant
  always @(negedge mclk)
  begin
    if (xbus_req === 1'b1)
      check({17'h0, xbus_addr}, qx.size() ? qx.pop_front() : 33'h1_ffff_ffff);
    if (ybus_req === 1'b1)
      check({17'h0, ybus_addr}, qy.size() ? qy.pop_front() : 33'h1_ffff_ffff);
    if (lbus_req === 1'b1 && lbus_gnt === 1'b1)
      check({lbus_long, lbus_addr}, ql.size() ? ql.pop_front() : 33'h1_ffff_ffff);
  end

  // Hang guard
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      close_out;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    reset = 1'b1;
    reg_wr = '0;
    reg_rd_idx = 4'h0;
    wrap_cfg = '0;
    dual_req = '0;
    single_req = '0;
    delay = 2'h0;
    for (int i = 2; i <= 9; i++)
      r[i] = 32'h0000_0000;
    void'($urandom(32'hd11d));
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    reset = 1'b0;
    chk_all();
    // Carry into the X upper half, Y upper kept, odd pointer, minus-two step
    wr(4'h4, 32'h0001_fffe);
    wr(4'h5, 32'h1234_5679);
    wr(4'h6, 32'h0001_fffe);
    wr(4'h7, 32'habcd_0010);
    wr(4'h8, 32'hffff_fffe);
    wr(4'h9, 32'h0000_fffc);
    wr(4'ha, 32'h5555_5555);
    dual(1'b0, dag_pkg::XY_MODE_INC, 1'b0, dag_pkg::XY_MODE_INC);
    dual(1'b1, dag_pkg::XY_MODE_KEEP, 1'b1, dag_pkg::XY_MODE_INDEX);
    dual(1'b0, dag_pkg::XY_MODE_INDEX, 1'b1, dag_pkg::XY_MODE_NONE);
    dual(1'b1, dag_pkg::XY_MODE_NONE, 1'b0, dag_pkg::XY_MODE_KEEP);
    idle();
    chk_all();
    // Wrap: both enables give Y only, then no wrap when not updating, then X alone
    wrap_cfg = {1'b1, 1'b1, 16'h1000, 16'h1008};
    wr(4'h4, 32'h0000_1008);
    wr(4'h6, 32'h0007_1008);
    dual(1'b0, dag_pkg::XY_MODE_INC, 1'b0, dag_pkg::XY_MODE_INC);
    idle();
    wrap_cfg.y_wrap_enable = 1'b0;
    wr(4'h4, 32'h0003_1008);
    dual(1'b0, dag_pkg::XY_MODE_KEEP, 1'b0, dag_pkg::XY_MODE_NONE);
    dual(1'b0, dag_pkg::XY_MODE_INDEX, 1'b0, dag_pkg::XY_MODE_NONE);
    idle();
    chk_all();
    wrap_cfg = '0;
    // Every single mode, word and long, every pointer, prompt and stalled grants
    for (int m = 0; m < 4; m++)
      for (int l = 0; l < 2; l++)
      begin
        delay = 2'($urandom);
        single(2'(m + l), 2'(m), 1'(l), 1'b0);
      end
    delay = 2'h3;
    single(2'h0, dag_pkg::S_MODE_INC, 1'b1, 1'b1);
    chk_all();
    // Random mix of writes, moves and read-backs
    wrap_cfg = dag_pkg::dag_wrap_cfg_t'({$urandom, 2'h0});
    wrap_cfg.wrap_start_addr[0] = 1'b0;
    wrap_cfg.wrap_end_addr[0] = 1'b0;
    for (int n = 0; n < 80; n++)
    begin
      v = 8'($urandom);
      case (v[7:6])
        2'h0: wr({1'b0, v[2:0]} + 4'h2, $urandom & 32'hffff_fffe);
        2'h1:
        begin
          dual(v[0], v[2:1], v[3], v[5:4]);
          idle();
        end
        2'h2:
        begin
          delay = v[6:5];
          single(v[1:0], v[3:2], v[4], 1'b0);
        end
        default: rd({1'b0, v[2:0]} + 4'h2, r[{1'b0, v[2:0]} + 4'h2]);
      endcase
    end
    idle();
    chk_all();
    check(33'(qx.size() + qy.size() + ql.size()), 33'h0);
    close_out();
  end
endmodule
